// >>> rtl/wr_bus_pkg.sv
// Package of constants and types shared by the store queue, both bus ends and the testbench
// Behaviour
// RL1 - Four-entry store queue captures data, address, size
// RL2 - Core stalls only when queue full
// RL3 - Data replaces address in first cycle's second phase; the code drives data one whole cycle after the address
// RL4 - Write completes in two cycles minimum
// RL5 - No bursts; each store is single write
// RL6 - Partial stores take two cycles: probe, capture
// RL7 - Write strobe asserted throughout each write
// RL8 - Address phase: address 31:4, lane selects 3:0
// RL9 - Data phase uses lanes chosen in address phase
// RL10 - Latch strobe lets memory capture address
// RL11 - Address bits 3:2 on dedicated outputs throughout
// RL12 - Output-enable held high; memory drivers off
// RL13 - Page hit: bits 31:10 match, no intervening read
// RL14 - Acknowledge ends write and stops data drive
// RL15 - Bus error ends write, raises no exception
// RL16 - Memory may end write by error alone
// RL17 - Error allowed while acknowledge awaited, inclusive
// RL18 - External system latches error into interrupt
// RL19 - Error wins over simultaneous acknowledge; later ignored
// RL20 - Memory must not rely on data after end
// RL21 - Stores issued in queue order
package wr_bus_pkg;
  localparam int ADDR_W      = 32;
  localparam int DATA_W      = 32;
  localparam int LANE_W      = 4;
  localparam int SIZE_W      = 2;
  localparam int QUEUE_DEPTH = 4;
  localparam int FIFO_DEPTH  = 8;
  localparam int PAGE_LO     = 10;
  localparam int ADDR_HI_LO  = 4;
  localparam int WORD_LO     = 2;
  localparam int ENTRY_W     = ADDR_W + DATA_W + SIZE_W;
  localparam logic [SIZE_W-1:0] SIZE_BYTE = 2'h0;
  localparam logic [SIZE_W-1:0] SIZE_HALF = 2'h1;
  localparam logic [SIZE_W-1:0] SIZE_WORD = 2'h2;
  localparam logic [ADDR_W-1:0] ADDR_RST  = 32'h00000000;
  localparam logic [DATA_W-1:0] DATA_RST  = 32'h00000000;
  localparam int MEM_LATENCY = 0;

  typedef enum logic [1:0]
  {
    BUS_IDLE = 2'b00,
    BUS_ADDR = 2'b01,
    BUS_DATA = 2'b10
  } bus_state_e;
endpackage

// >>> rtl/wr_bus_if.sv
// Interface carrying the multiplexed write bus between processor end and memory end
`timescale 1ns/1ps
interface wr_bus_if;
  logic [31:0] ad_out;
  logic        ad_oe;
  logic        write_strobe;
  logic        addr_latch;
  logic [1:0]  addr_word;
  logic        memory_drive_gate;
  logic        same_page_write;
  logic        ack;
  logic        transfer_fail_in;

  modport cpu
  (
    output ad_out,
    output ad_oe,
    output write_strobe,
    output addr_latch,
    output addr_word,
    output memory_drive_gate,
    output same_page_write,
    input  ack,
    input  transfer_fail_in
  );

  modport mem
  (
    input  ad_out,
    input  ad_oe,
    input  write_strobe,
    input  addr_latch,
    input  addr_word,
    input  memory_drive_gate,
    input  same_page_write,
    output ack,
    output transfer_fail_in
  );
endinterface

// >>> rtl/store_fifo.sv
// Parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module store_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
)(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign in_ready  = (count != (PW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end

  genvar i;
  generate
    for (i = 0; i < DEPTH; i++)
    begin : g_slot
      always_ff @(posedge clk)
      begin
        if (push && wr_ptr == PW'(i))
          mem[i] <= in_data;
      end
    end
  endgenerate
endmodule

// >>> rtl/cpu_write_end.sv
// Processor end: store queue feeding single write transactions on the multiplexed bus
`timescale 1ns/1ps
module cpu_write_end (
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic                         store_valid,
  input  wire logic [wr_bus_pkg::ADDR_W-1:0] store_addr,
  input  wire logic [wr_bus_pkg::DATA_W-1:0] store_data,
  input  wire logic [wr_bus_pkg::SIZE_W-1:0] store_size,
  input  wire logic                         cache_hit,
  input  wire logic [wr_bus_pkg::DATA_W-1:0] cache_word,
  input  wire logic                         other_transfer,
  output logic                              core_stall,
  output logic                              cache_write,
  output logic [wr_bus_pkg::DATA_W-1:0]     cache_wdata,
  output logic                              write_done,
  output logic                              write_failed,
  wr_bus_if.cpu                             bus
);
  // ****************************************************************
  // Store capture
  // ****************************************************************
  logic                          probe_done;
  logic                          q_in_ready;
  logic [wr_bus_pkg::ENTRY_W-1:0] q_out;
  logic                          q_out_valid;
  wire  partial  = store_size != wr_bus_pkg::SIZE_WORD;
  // Partial store waits one probe cycle before the queue takes it
  wire  can_take = !partial || probe_done;                             // RL6
  wire  q_push   = store_valid && can_take && q_in_ready;
  wire  q_pop;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      probe_done <= 1'b0;
    else
      probe_done <= store_valid && partial && !probe_done;             // RL6
  end

  // Hit word merge for partial stores
  logic [wr_bus_pkg::DATA_W-1:0] merged;
  logic [wr_bus_pkg::LANE_W-1:0] lanes_in;
  always_comb
  begin
    lanes_in = lane_sel(store_addr[1:0], store_size);
    for (int b = 0; b < 4; b++)
      merged[b*8 +: 8] = lanes_in[b] ? store_data[b*8 +: 8] : cache_word[b*8 +: 8];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      core_stall  <= 1'b0;
      cache_write <= 1'b0;
      cache_wdata <= wr_bus_pkg::DATA_RST;
    end
    else
    begin
      // Core only stalls when every entry is taken
      core_stall  <= store_valid && !q_in_ready;                       // RL2
      cache_write <= store_valid && partial && !probe_done && cache_hit;  // RL6
      cache_wdata <= merged;
    end
  end

  // Queue order preserves store order on the bus
  store_fifo #(
    .WIDTH (wr_bus_pkg::ENTRY_W),
    .DEPTH (wr_bus_pkg::QUEUE_DEPTH)
  ) u_queue (                                                          // RL1 RL21
    .clk       (clk),
    .rst       (rst),
    .in_data   ({store_size, store_addr, store_data}),
    .in_valid  (store_valid && can_take),
    .in_ready  (q_in_ready),
    .out_data  (q_out),
    .out_valid (q_out_valid),
    .out_ready (q_pop)
  );

  function automatic logic [3:0] lane_sel(input logic [1:0] a, input logic [1:0] s);
    logic [3:0] r;
    r = 4'hF;
    if (s == wr_bus_pkg::SIZE_BYTE)
      r = 4'h1 << a;
    else if (s == wr_bus_pkg::SIZE_HALF)
      r = a[1] ? 4'hC : 4'h3;
    return r;
  endfunction

  // ****************************************************************
  // Bus sequencer
  // ****************************************************************
  wr_bus_pkg::bus_state_e state;
  logic [wr_bus_pkg::DATA_W-1:0] hold_data;
  logic [wr_bus_pkg::ADDR_W-1:0] hold_addr;
  logic [3:0]                    hold_lanes;
  logic [wr_bus_pkg::ADDR_W-1:0] last_addr;
  logic                          last_valid;
  wire [wr_bus_pkg::DATA_W-1:0]  e_data = q_out[wr_bus_pkg::DATA_W-1:0];
  wire [wr_bus_pkg::ADDR_W-1:0]  e_addr = q_out[wr_bus_pkg::DATA_W +: wr_bus_pkg::ADDR_W];
  wire [1:0]                     e_size = q_out[wr_bus_pkg::ENTRY_W-1 -: 2];
  wire [3:0]                     e_lanes = lane_sel(e_addr[1:0], e_size);
  wire  start    = (state == wr_bus_pkg::BUS_IDLE) && q_out_valid;
  // Slot is freed once the entry sits in the holding register
  assign q_pop   = start;                                              // RL5
  wire  finish   = (state == wr_bus_pkg::BUS_DATA) && (bus.ack || bus.transfer_fail_in);  // RL14 RL15
  wire  page_hit = last_valid &&
                   e_addr[wr_bus_pkg::ADDR_W-1:wr_bus_pkg::PAGE_LO] ==
                   last_addr[wr_bus_pkg::ADDR_W-1:wr_bus_pkg::PAGE_LO];  // RL13

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      state <= wr_bus_pkg::BUS_IDLE;
    else
      case (state)
        wr_bus_pkg::BUS_IDLE: if (start) state <= wr_bus_pkg::BUS_ADDR;
        wr_bus_pkg::BUS_ADDR: state <= wr_bus_pkg::BUS_DATA;             // RL3 RL4
        wr_bus_pkg::BUS_DATA: if (finish) state <= wr_bus_pkg::BUS_IDLE;
        default:              state <= wr_bus_pkg::BUS_IDLE;
      endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      hold_data  <= wr_bus_pkg::DATA_RST;
      hold_addr  <= wr_bus_pkg::ADDR_RST;
      hold_lanes <= 4'h0;
      last_addr  <= wr_bus_pkg::ADDR_RST;
      last_valid <= 1'b0;
    end
    else
    begin
      if (start)
      begin
        hold_data  <= e_data;
        hold_addr  <= e_addr;
        hold_lanes <= e_lanes;
        last_addr  <= e_addr;
        last_valid <= 1'b1;
      end
      else if (other_transfer)
        last_valid <= 1'b0;                                            // RL13
    end
  end

  // ****************************************************************
  // Pin drive, all registered
  // ****************************************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bus.ad_out            <= wr_bus_pkg::DATA_RST;
      bus.ad_oe             <= 1'b0;
      bus.write_strobe      <= 1'b0;
      bus.addr_latch        <= 1'b0;
      bus.addr_word         <= 2'h0;
      bus.memory_drive_gate <= 1'b1;
      bus.same_page_write   <= 1'b0;
      write_done            <= 1'b0;
      write_failed          <= 1'b0;
    end
    else
    begin
      write_done   <= finish;
      // Error wins when both arrive; no exception, only a report pulse
      write_failed <= finish && bus.transfer_fail_in;                  // RL15 RL19
      bus.memory_drive_gate <= 1'b1;                                   // RL12
      if (start)
      begin
        bus.ad_out          <= {e_addr[31:wr_bus_pkg::ADDR_HI_LO], e_lanes};  // RL8
        bus.ad_oe           <= 1'b1;
        bus.write_strobe    <= 1'b1;                                   // RL7
        bus.addr_latch      <= 1'b1;                                   // RL10
        bus.addr_word       <= e_addr[3:wr_bus_pkg::WORD_LO];         // RL11
        bus.same_page_write <= page_hit;                               // RL13
      end
      else if (state == wr_bus_pkg::BUS_ADDR)
      begin
        // Whole cycles only, so data follows one cycle after the address
        bus.ad_out          <= hold_data;                              // RL3 RL9
        bus.addr_latch      <= 1'b0;
        bus.same_page_write <= 1'b0;
      end
      else if (finish)
      begin
        bus.ad_oe        <= 1'b0;                                      // RL14
        bus.write_strobe <= 1'b0;
      end
    end
  end
endmodule

// >>> rtl/mem_write_end.sv
// Memory end: latches address, takes data through an 8-word FIFO, answers ack or error
`timescale 1ns/1ps
module mem_write_end (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          fail_req,
  output logic [wr_bus_pkg::ADDR_W-1:0]      wr_addr,
  output logic [wr_bus_pkg::DATA_W-1:0]      wr_data,
  output logic [wr_bus_pkg::LANE_W-1:0]      wr_lanes,
  output logic                               wr_valid,
  input  wire logic                          wr_ready,
  output logic                               page_hint,
  output logic                               fail_seen,
  input  wire logic                          fail_clear,
  wr_bus_if.mem                              bus
);
  localparam int FW = wr_bus_pkg::ADDR_W + wr_bus_pkg::DATA_W + wr_bus_pkg::LANE_W;
  logic [wr_bus_pkg::ADDR_W-1:0] lat_addr;
  logic [3:0]                    lat_lanes;
  logic                          lat_page;
  logic                          in_data;
  logic                          fifo_ready;
  logic [FW-1:0]                 f_out;
  logic                          f_valid;
  // Data is taken at the answer, never after it
  wire  answer = in_data && bus.write_strobe && fifo_ready;           // RL14 RL20

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lat_addr  <= wr_bus_pkg::ADDR_RST;
      lat_lanes <= 4'h0;
      lat_page  <= 1'b0;
      in_data   <= 1'b0;
    end
    else
    begin
      if (bus.addr_latch)
      begin
        lat_addr  <= {bus.ad_out[31:4], bus.addr_word, 2'h0};          // RL10
        lat_lanes <= bus.ad_out[3:0];
        lat_page  <= bus.same_page_write;
        in_data   <= 1'b1;
      end
      else if (answer || !bus.write_strobe)
        in_data <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bus.ack              <= 1'b0;
      bus.transfer_fail_in <= 1'b0;
      page_hint            <= 1'b0;
      fail_seen            <= 1'b0;
    end
    else
    begin
      // Pulse one cycle; error alone ends the write
      bus.ack              <= answer && !fail_req && !bus.ack;         // RL16
      bus.transfer_fail_in <= answer && fail_req && !bus.transfer_fail_in;  // RL17
      page_hint            <= lat_page;
      // Latched for an interrupt; a new error beats the clear
      if (bus.transfer_fail_in)
        fail_seen <= 1'b1;                                             // RL18
      else if (fail_clear)
        fail_seen <= 1'b0;
    end
  end

  // Drive nothing at any time; take data only while the processor's gate is high
  store_fifo #(
    .WIDTH (FW),
    .DEPTH (wr_bus_pkg::FIFO_DEPTH)
  ) u_fifo (                                                           // RL12
    .clk       (clk),
    .rst       (rst),
    .in_data   ({lat_addr, bus.ad_out, lat_lanes}),
    .in_valid  (answer && !bus.ack && !bus.transfer_fail_in && !fail_req && bus.memory_drive_gate),
    .in_ready  (fifo_ready),
    .out_data  (f_out),
    .out_valid (f_valid),
    .out_ready (wr_ready)
  );

  assign wr_addr  = f_out[FW-1 -: wr_bus_pkg::ADDR_W];
  assign wr_data  = f_out[wr_bus_pkg::LANE_W +: wr_bus_pkg::DATA_W];
  assign wr_lanes = f_out[3:0];
  assign wr_valid = f_valid;
endmodule

// >>> bench/wr_bus_monitor.sv
// Assertion checker watching the write bus between the processor end and the memory end
`timescale 1ns/1ps
module wr_bus_monitor (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [31:0] ad_out,
  input wire logic        ad_oe,
  input wire logic        write_strobe,
  input wire logic        addr_latch,
  input wire logic [1:0]  addr_word,
  input wire logic        memory_drive_gate,
  input wire logic        same_page_write,
  input wire logic        ack,
  input wire logic        transfer_fail_in
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_latch_in_write: assert property (addr_latch |-> write_strobe && ad_oe)
    else $error("latch strobe outside a write");
  a_latch_one_cycle: assert property (addr_latch |=> !addr_latch)
    else $error("address held past first cycle");
  a_start_with_addr: assert property ($rose(write_strobe) |-> addr_latch)
    else $error("write began without address");
  a_lane_code: assert property (addr_latch |-> ad_out[3:0] inside {4'h1, 4'h2, 4'h4, 4'h8,
                                4'h3, 4'hC, 4'hF})
    else $error("illegal lane select code");
  a_two_cycle_min: assert property ($rose(write_strobe) |=> write_strobe)
    else $error("write shorter than two cycles");
  a_no_burst: assert property (write_strobe && !$rose(write_strobe) |-> !addr_latch)
    else $error("second address inside one write");
  a_word_steady: assert property (write_strobe && !$rose(write_strobe) |-> $stable(addr_word))
    else $error("word address moved during write");
  a_gate_high: assert property (memory_drive_gate)
    else $error("memory drive gate went low");
  a_drive_in_write: assert property (ad_oe == write_strobe)
    else $error("bus drive differs from write strobe");
  a_answer_ends: assert property (write_strobe && !addr_latch && (ack || transfer_fail_in)
                                  |=> !write_strobe)
    else $error("write not ended by answer");
  a_end_has_cause: assert property ($fell(write_strobe) |-> $past(ack) || $past(transfer_fail_in))
    else $error("write ended without answer");
  a_answer_in_data: assert property (ack || transfer_fail_in |-> write_strobe && ad_oe && !addr_latch)
    else $error("answer outside the data cycle");
endmodule

// >>> bench/test_cpu_bus_write_interface.sv
// Testbench joining both ends of the write bus and checking stores end to end
`timescale 1ns/1ps
module test_cpu_bus_write_interface;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        store_valid = 1'b0;
  logic [31:0] store_addr = 32'h0;
  logic [31:0] store_data = 32'h0;
  logic [1:0]  store_size = 2'h0;
  logic        cache_hit = 1'b0;
  logic [31:0] cache_word = 32'h0;
  logic        other_transfer = 1'b0;
  logic        fail_req = 1'b0;
  logic        wr_ready = 1'b0;
  logic        fail_clear = 1'b0;
  logic        core_stall, cache_write, write_done, write_failed, wr_valid, page_hint, fail_seen;
  logic [31:0] cache_wdata, wr_addr, wr_data, prev, seed = 32'h0000001D;
  logic [3:0]  wr_lanes;
  logic [65:0] exp_q[$];
  logic        page_q[$];
  logic [31:0] merge_exp;
  logic        hold = 1'b1, watch = 1'b1, have_prev = 1'b0, stall_seen = 1'b0, page_exp = 1'b0;
  int          num_errors = 0, check_count = 0, cycles = 0, n_stores = 0, n_done = 0, n_fail = 0;

  wr_bus_if wb ();
  cpu_write_end i_cpu_write_end (.clk(clk), .rst(rst), .store_valid(store_valid),
    .store_addr(store_addr), .store_data(store_data), .store_size(store_size),
    .cache_hit(cache_hit), .cache_word(cache_word), .other_transfer(other_transfer),
    .core_stall(core_stall), .cache_write(cache_write), .cache_wdata(cache_wdata),
    .write_done(write_done), .write_failed(write_failed), .bus(wb));
  mem_write_end i_mem_write_end (.clk(clk), .rst(rst), .fail_req(fail_req), .wr_addr(wr_addr),
    .wr_data(wr_data), .wr_lanes(wr_lanes), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .page_hint(page_hint), .fail_seen(fail_seen), .fail_clear(fail_clear), .bus(wb));
  wr_bus_monitor i_wr_bus_monitor (.clk(clk), .rst(rst), .ad_out(wb.ad_out), .ad_oe(wb.ad_oe),
    .write_strobe(wb.write_strobe), .addr_latch(wb.addr_latch), .addr_word(wb.addr_word),
    .memory_drive_gate(wb.memory_drive_gate), .same_page_write(wb.same_page_write),
    .ack(wb.ack), .transfer_fail_in(wb.transfer_fail_in));

  always #12.5 clk = ~clk;

  function automatic logic [31:0] mask(input logic [3:0] ln);
    return {{8{ln[3]}}, {8{ln[2]}}, {8{ln[1]}}, {8{ln[0]}}};
  endfunction

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  task automatic check(input string what, input logic [65:0] seen, input logic [65:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    if (num_errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Partial stores spend a probe edge before every capture attempt; a stalled
  // capture sends them back to a probe. Valid stays high for the next store, so
  // the caller lowers it after the last one.
  task automatic put(input logic [31:0] a, input logic [1:0] sz);
    logic [31:0] d;
    logic [3:0]  ln;
    d = rnd();
    ln = sz == wr_bus_pkg::SIZE_WORD ? 4'hF : sz == wr_bus_pkg::SIZE_HALF ?
         (a[1] ? 4'hC : 4'h3) : 4'h1 << a[1:0];
    exp_q.push_back({a[31:2], d & mask(ln), ln});
    page_q.push_back(have_prev && a[31:10] == prev[31:10]);
    have_prev = 1'b1;
    prev = a;
    cache_word = rnd();
    cache_hit = cache_word[0];
    merge_exp = (cache_word & ~mask(ln)) | (d & mask(ln));
    {store_addr, store_data, store_size, store_valid} = {a, d, sz, 1'b1};
    do
    begin
      if (sz != wr_bus_pkg::SIZE_WORD)
      begin
        @(posedge clk);
        #2;
      end
      @(posedge clk);
      #2;
    end
    while (core_stall);
    n_stores++;
  endtask

  task automatic drain();
    repeat (2000)
      if (exp_q.size() != 0)
        @(posedge clk);
    repeat (4) @(posedge clk);
    #2;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    wr_ready <= !hold && cycles[1:0] != 2'h3;
    if (cycles > 30000)
    begin
      num_errors++;
      report_and_stop();
    end
  end

  // Watcher: memory writes and address phases are paired with the oldest note of the driver
  always @(posedge clk)
    if (!rst)
    begin
      if (core_stall)
        stall_seen = 1'b1;
      if (write_done)
        n_done++;
      if (write_failed)
        n_fail++;
      if (cache_write)
        check("cache_wdata", cache_wdata, merge_exp);
      if (wb.addr_latch && page_q.size() > 0)
      begin
        page_exp = page_q.pop_front();
        check("same_page_write", wb.same_page_write, page_exp);
      end
      if (wb.ack || wb.transfer_fail_in)
        check("page_hint", page_hint, page_exp);
      if (wr_valid && wr_ready && watch)
      begin
        if (exp_q.size() == 0)
          check("extra write", 66'h1, 66'h0);
        else
          check("write", {wr_addr[31:2], wr_data & mask(wr_lanes), wr_lanes},
                exp_q.pop_front());
      end
    end

  initial
  begin
    logic [31:0] r;
    logic [1:0]  sz;
    repeat (20) @(posedge clk);
    #2 rst = 1'b0;
    hold = 1'b0;
    repeat (60)
    begin
      r = rnd();
      sz = r[14:13] == 2'h3 ? wr_bus_pkg::SIZE_WORD : r[14:13];
      put({19'h0, r[12:2], sz == wr_bus_pkg::SIZE_BYTE ? r[1:0] :
           sz == wr_bus_pkg::SIZE_HALF ? {r[1], 1'b0} : 2'h0}, sz);
    end
    store_valid = 1'b0;
    drain();
    // Memory stalls: its FIFO fills, it withholds answers, the store queue fills
    hold = 1'b1;
    fork
      begin
        repeat (14) put(32'h00040000 | (rnd() & 32'h00000FFC), wr_bus_pkg::SIZE_WORD);
        store_valid = 1'b0;
      end
      begin
        repeat (300) @(posedge clk);
        hold = 1'b0;
      end
    join
    check("core_stall seen", stall_seen, 1'b1);
    drain();
    check("write_done count", n_done, n_stores);
    other_transfer = 1'b1;
    @(posedge clk);
    #2 other_transfer = 1'b0;
    have_prev = 1'b0;
    repeat (2) put(32'h00040010, wr_bus_pkg::SIZE_WORD);
    store_valid = 1'b0;
    drain();
    watch = 1'b0;
    fail_req = 1'b1;
    put(32'h00080004, wr_bus_pkg::SIZE_WORD);
    store_valid = 1'b0;
    repeat (20) @(posedge clk);
    #2 fail_req = 1'b0;
    check("write_failed count", n_fail, 1);
    check("fail_seen", fail_seen, 1'b1);
    fail_clear = 1'b1;
    repeat (2) @(posedge clk);
    #2 fail_clear = 1'b0;
    check("fail_seen cleared", fail_seen, 1'b0);
    report_and_stop();
  end
endmodule
